// ==== sem_defs.svh ====
// Constants for the semaphore port controller
`ifndef SEM_DEFS_SVH
`define SEM_DEFS_SVH
`define ADDR_W 15
`define DATA_W 8
`define IDX_W 3
`define CLAIM_VAL 8'h00
`define FREE_VAL 8'hFF
// Setup before write strobe, write strobe width, read time (ns)
`define SETUP_NS 30
`define STROBE_NS 30
`define READ_NS 40
`define CLK_NS 10
`define SETUP_CYC ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define READ_CYC ((`READ_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 4
`define IDLE_GAP 4'h1
`endif

// ==== sem_dev.sv ====
// Behavioural model of the device's semaphore latches
module sem_dev (
    // Left port
    input sem_pkg::pins_t pins,
    input wire logic [7:0] bus_drv,
    input wire logic bus_oe,
    output logic [7:0] bus_rd,
    // Right port
    input wire logic r_we,
    input wire logic [2:0] r_idx,
    input wire logic r_d0
);
    // Owner 0 free, 1 left, 2 right
    logic [1:0] owner [8];
    logic [7:0] req_l = 8'hFF;
    logic [7:0] req_r = 8'hFF;
    logic hold_l = 1'b1;
    logic [7:0] last = 8'h00;
    function automatic logic [1:0] settle(logic [1:0] o, logic rl, logic rr);
        if (o == 2'd1 && rl) o = rr ? 2'd0 : 2'd2;
        if (o == 2'd2 && rr) o = rl ? 2'd0 : 2'd1;
        if (o == 2'd0) o = !rl ? 2'd1 : (!rr ? 2'd2 : 2'd0);
        return o;
    endfunction
    initial begin
        for (int i = 0; i < 8; i++) owner[i] = 2'd0;
    end
    always @(posedge pins.read_write_n) begin
        if (!pins.flag_space_select_n && bus_oe) begin
            req_l[pins.addr[2:0]] = bus_drv[0];
            owner[pins.addr[2:0]] = settle(owner[pins.addr[2:0]],
                req_l[pins.addr[2:0]], req_r[pins.addr[2:0]]);
        end
    end
    always @(posedge r_we) begin
        req_r[r_idx] = r_d0;
        owner[r_idx] = settle(owner[r_idx], req_l[r_idx], r_d0);
    end
    always @(negedge pins.output_enable_n) begin
        if (!pins.flag_space_select_n) hold_l = owner[pins.addr[2:0]] != 2'd1;
    end
    always @(posedge pins.output_enable_n) last = {8{!hold_l}};
    assign bus_rd = (!pins.flag_space_select_n && !pins.output_enable_n)
        ? {8{hold_l}} : last;
endmodule

// ==== sem_pkg.sv ====
// Types for the semaphore port controller
package sem_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_setup = 3'h1,
        st_strobe = 3'h3,
        st_hold = 3'h7,
        st_read = 3'h6,
        st_gap = 3'h4
    } state_t;
    typedef enum logic [1:0] {
        op_claim = 2'b00,
        op_release = 2'b01,
        op_poll = 2'b10
    } op_t;
    typedef struct packed {
        op_t op;
        logic [2:0] index;
    } cmd_t;
    typedef struct packed {
        logic done;
        logic granted;
        logic [7:0] data;
    } result_t;
    typedef struct packed {
        logic chip_enable_n;
        logic flag_space_select_n;
        logic output_enable_n;
        logic read_write_n;
        logic [14:0] addr;
    } pins_t;
endpackage

// ==== sem_port_ctrl.sv ====
// Port controller claiming and releasing semaphores of a dual-port RAM
//
// Overview of operation
// [RQ1] Device is master with role pin high, slave with it low.
// [RQ2] Slave uses incoming collision indicator only as write inhibit.
// [RQ3] Exactly one cascaded device is configured master.
// [RQ4] Master arbitration uses only enables and addresses, not read/write.
// [RQ5] Controller holds address and enable valid before starting write pulse.
// [RQ6] Device holds eight semaphore latches independent of the array.
// [RQ7] Simultaneous semaphore accesses never give ambiguous results.
// [RQ8] Port with both enables high enters standby.
// [RQ9] Flags active low: write zero requests, same port writing one releases.
// [RQ10] Semaphores live in separate space selected by flag-space select low.
// [RQ11] Only the three lowest address lines select a semaphore.
// [RQ12] Semaphore write uses only the least significant data line.
// [RQ13] Zero into free flag: writer reads zero, other reads one.
// [RQ14] Owner writing one frees flag unless other request pending.
// [RQ15] Non-owner zero is held in its request latch until freed.
// [RQ16] Semaphore read replicates the flag onto all data bits.
// [RQ17] Read value latched while select and output enable stay active.
// [RQ18] Polling controller deasserts select or output enable between reads.
// [RQ19] Claim by writing zero then reading back; zero means success.
// [RQ20] Request on held flag: request latch zero, flag reads one.
// [RQ21] After failed claim, keep polling or withdraw by writing one.
// [RQ22] Pending other request takes ownership when owner writes one.
// [RQ23] Simultaneous requests: exactly one port wins.
// [RQ24] Slave blocks writes on a port with active collision indicator.
// [RQ25] Master never drives both collision indicators low together.
`include "sem_defs.svh"
module sem_port_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command side
    input wire logic cmd_valid,
    input sem_pkg::cmd_t cmd,
    output logic cmd_ready,
    output sem_pkg::result_t result,
    // Device port pins
    output sem_pkg::pins_t pins,
    input wire logic [`DATA_W-1:0] data_in,
    output logic [`DATA_W-1:0] data_out,
    output logic data_oe
);
    // ----------------------------------------------------------------
    // State and next values
    // ----------------------------------------------------------------
    logic [`DATA_W-1:0] rd_sync;
    sem_pkg::state_t state_reg, state_next;
    sem_pkg::cmd_t cmd_reg, cmd_next;
    logic [`CNT_W-1:0] cnt_reg, cnt_next;
    sem_pkg::pins_t pins_reg, pins_next;
    logic [`DATA_W-1:0] dout_reg, dout_next;
    logic oe_reg, oe_next;
    logic ready_reg, ready_next;
    sem_pkg::result_t res_reg, res_next;

    // ----------------------------------------------------------------
    // Data bus synchroniser
    // ----------------------------------------------------------------
    sem_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d_async(data_in),
        .d_sync(rd_sync)
    );

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Pins for a semaphore access at the given index
    function automatic sem_pkg::pins_t sem_pins(input logic [2:0] idx,
                                               input logic oe_n,
                                               input logic rw_n);
        sem_pkg::pins_t p;
        p.chip_enable_n = 1'b1;
        p.flag_space_select_n = 1'b0; // RQ10
        p.output_enable_n = oe_n;
        p.read_write_n = rw_n;
        p.addr = {{(`ADDR_W-`IDX_W){1'b0}}, idx}; // RQ11
        return p;
    endfunction

    // Standby pins: both enables high
    function automatic sem_pkg::pins_t idle_pins();
        sem_pkg::pins_t p;
        p.chip_enable_n = 1'b1;
        p.flag_space_select_n = 1'b1; // RQ8
        p.output_enable_n = 1'b1;
        p.read_write_n = 1'b1;
        p.addr = `ADDR_W'h0000;
        return p;
    endfunction

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        cnt_next = cnt_reg;
        pins_next = pins_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        ready_next = ready_reg;
        res_next = res_reg;
        res_next.done = 1'b0;
        case (state_reg)
            sem_pkg::st_idle: begin
                if (cmd_valid && ready_reg) begin
                    ready_next = 1'b0;
                    cmd_next = cmd;
                    if (cmd.op == sem_pkg::op_poll) begin
                        // Poll reads only, no write
                        pins_next = sem_pins(cmd.index, 1'b0, 1'b1);
                        cnt_next = `CNT_W'(`READ_CYC);
                        state_next = sem_pkg::st_read;
                    end else begin
                        // Address and select first, write strobe later
                        pins_next = sem_pins(cmd.index, 1'b1, 1'b1); // RQ5
                        dout_next = (cmd.op == sem_pkg::op_claim) ?
                            `CLAIM_VAL : `FREE_VAL; // RQ9 RQ12 RQ21
                        oe_next = 1'b1;
                        cnt_next = `CNT_W'(`SETUP_CYC);
                        state_next = sem_pkg::st_setup;
                    end
                end
            end
            sem_pkg::st_setup: begin
                cnt_next = cnt_reg - `CNT_W'(1);
                if (cnt_reg == `CNT_W'(1)) begin
                    pins_next.read_write_n = 1'b0; // RQ5
                    cnt_next = `CNT_W'(`STROBE_CYC);
                    state_next = sem_pkg::st_strobe;
                end
            end
            sem_pkg::st_strobe: begin
                cnt_next = cnt_reg - `CNT_W'(1);
                if (cnt_reg == `CNT_W'(1)) begin
                    pins_next.read_write_n = 1'b1;
                    state_next = sem_pkg::st_hold;
                end
            end
            sem_pkg::st_hold: begin
                oe_next = 1'b0;
                if (cmd_reg.op == sem_pkg::op_claim) begin
                    // Write then read back to test the claim
                    pins_next.output_enable_n = 1'b0; // RQ19
                    cnt_next = `CNT_W'(`READ_CYC);
                    state_next = sem_pkg::st_read;
                end else begin
                    pins_next = idle_pins();
                    res_next.done = 1'b1;
                    res_next.granted = 1'b0;
                    res_next.data = `FREE_VAL;
                    cnt_next = `IDLE_GAP;
                    state_next = sem_pkg::st_gap;
                end
            end
            sem_pkg::st_read: begin
                cnt_next = cnt_reg - `CNT_W'(1);
                // Wait one extra cycle past the read time
                if (cnt_reg == `CNT_W'(0)) begin
                    // Zero read back means the token is ours
                    res_next.done = 1'b1;
                    res_next.granted = ~rd_sync[0]; // RQ19 RQ13
                    res_next.data = rd_sync;
                    pins_next = idle_pins(); // RQ18
                    cnt_next = `IDLE_GAP;
                    state_next = sem_pkg::st_gap;
                end
            end
            sem_pkg::st_gap: begin
                // Select high between polls so latch reloads
                cnt_next = cnt_reg - `CNT_W'(1);
                if (cnt_reg == `CNT_W'(0)) begin
                    ready_next = 1'b1; // RQ18
                    state_next = sem_pkg::st_idle;
                end
            end
            default: begin
                state_next = sem_pkg::st_idle;
                pins_next = idle_pins();
                oe_next = 1'b0;
                ready_next = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= sem_pkg::st_idle;
            cmd_reg <= '0;
            cnt_reg <= `CNT_W'h0;
            pins_reg <= {1'b1, 1'b1, 1'b1, 1'b1, `ADDR_W'h0000};
            dout_reg <= `DATA_W'h00;
            oe_reg <= 1'b0;
            ready_reg <= 1'b1;
            res_reg <= '0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            cnt_reg <= cnt_next;
            pins_reg <= pins_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            ready_reg <= ready_next;
            res_reg <= res_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign cmd_ready = ready_reg;
    assign result = res_reg;
    assign pins = pins_reg;
    assign data_out = dout_reg;
    assign data_oe = oe_reg;
endmodule

// ==== sem_port_ctrl_chk.sv ====
// Checker for the semaphore port controller
module sem_port_ctrl_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command side
    input wire logic cmd_valid,
    input sem_pkg::cmd_t cmd,
    input wire logic cmd_ready,
    input sem_pkg::result_t result,
    // Device side
    input sem_pkg::pins_t pins,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    wire sel_n = pins.flag_space_select_n;
    wire rw_n = pins.read_write_n;
    wire oe_n = pins.output_enable_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_strobe;
        (!rw_n && !sel_n && $stable(pins.addr))[*3] ##1 rw_n;
    endsequence
    sequence s_readback;
        !oe_n && !sel_n && !data_oe;
    endsequence
    property p_setup;
        $fell(rw_n) |-> !$past(sel_n, 3) && $past(pins.addr, 3) == pins.addr;
    endproperty
    a_setup: assert property (p_setup) else $error("short setup");
    property p_strobe;
        $fell(rw_n) |-> s_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("bad strobe");
    property p_wdata;
        !rw_n |-> data_oe && (data_out == 8'h00 || data_out == 8'hFF);
    endproperty
    a_wdata: assert property (p_wdata) else $error("bad write data");
    property p_gap;
        $rose(sel_n) |-> sel_n && oe_n ##1 sel_n && oe_n;
    endproperty
    a_gap: assert property (p_gap) else $error("no standby gap");
    property p_readback;
        $rose(rw_n) && data_out == 8'h00 |=> s_readback;
    endproperty
    a_readback: assert property (p_readback) else $error("no read");
    property p_claim_done;
        cmd_valid && cmd_ready && cmd.op == sem_pkg::op_claim
            |-> ##13 result.done;
    endproperty
    a_claim_done: assert property (p_claim_done) else $error("late");
endmodule
bind sem_port_ctrl sem_port_ctrl_chk chk_u (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .result(result), .pins(pins), .data_out(data_out), .data_oe(data_oe));

// ==== sem_sync.sv ====
// Two-flop synchroniser for the data bus of the port
`include "sem_defs.svh"
module sem_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Data
    input wire logic [`DATA_W-1:0] d_async,
    output logic [`DATA_W-1:0] d_sync
);
    logic [`DATA_W-1:0] s1_reg;
    logic [`DATA_W-1:0] s2_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= `DATA_W'h00;
            s2_reg <= `DATA_W'h00;
        end else begin
            s1_reg <= d_async;
            s2_reg <= s1_reg;
        end
    end
    assign d_sync = s2_reg;
endmodule

// ==== test_dual_port_semaphore_and_busy_cascade.sv ====
// Testbench for the semaphore port controller
module test_dual_port_semaphore_and_busy_cascade;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, cmd_valid = 0, cmd_ready, data_oe;
    logic r_we = 0, r_d0 = 1;
    logic [2:0] r_idx = 3'h0;
    sem_pkg::cmd_t cmd = '0;
    sem_pkg::result_t result;
    sem_pkg::pins_t pins;
    logic [7:0] data_in, data_out, bus_rd;
    int n_mismatch = 0, checked = 0;
    always #5 clk = ~clk;
    assign data_in = data_oe ? data_out : bus_rd;
    sem_port_ctrl dut_u (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .result(result), .pins(pins),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    sem_dev dev_u (.pins(pins), .bus_drv(data_out), .bus_oe(data_oe),
        .bus_rd(bus_rd), .r_we(r_we), .r_idx(r_idx), .r_d0(r_d0));
    task check(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task do_op(sem_pkg::op_t op, logic [2:0] idx, logic [7:0] exp);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        cmd = '{op, idx};
        cmd_valid = 1;
        @(posedge clk);
        #1 cmd_valid = 0;
        n = 0;
        while (result.done !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1 n++;
        end
        check("done", {7'h0, result.done}, 8'h01);
        check("data", result.data, exp);
        check("granted", {7'h0, result.granted}, {7'h0, ~exp[0]});
    endtask
    task r_write(logic [2:0] idx, logic d);
        r_idx = idx;
        r_d0 = d;
        r_we = 1;
        @(posedge clk);
        #1 r_we = 0;
        @(posedge clk);
        #1;
    endtask
    task t_claim_all;
        for (int i = 0; i < 8; i++)
            do_op(sem_pkg::op_claim, 3'(i), 8'h00);
        for (int i = 0; i < 8; i++)
            do_op(sem_pkg::op_release, 3'(i), 8'hFF);
        do_op(sem_pkg::op_claim, 3'h5, 8'h00);
        do_op(sem_pkg::op_release, 3'h5, 8'hFF);
    endtask
    task t_contend;
        r_write(3'h2, 1'b0);
        do_op(sem_pkg::op_claim, 3'h2, 8'hFF);
        // Right frees mid-read; latched read must stay at one
        fork
            do_op(sem_pkg::op_poll, 3'h2, 8'hFF);
            begin
                @(negedge pins.output_enable_n);
                repeat (2) @(posedge clk);
                #1 r_write(3'h2, 1'b1);
            end
        join
        do_op(sem_pkg::op_poll, 3'h2, 8'h00);
        do_op(sem_pkg::op_release, 3'h2, 8'hFF);
        r_write(3'h2, 1'b0);
        do_op(sem_pkg::op_poll, 3'h2, 8'hFF);
        r_write(3'h2, 1'b1);
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 reset_n = 1;
        check("ready", {7'h0, cmd_ready}, 8'h01);
        check("select", {7'h0, pins.flag_space_select_n}, 8'h01);
        t_claim_all();
        t_contend();
        end_of_test();
    end
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
endmodule
